// ==== pkg/did_defines.svh ====
`ifndef DID_DEFINES_SVH
`define DID_DEFINES_SVH

// Serial word layout, bit positions within the 24-bit command
`define DID_RW_BIT        23
`define DID_DEV_HI_BIT    22
`define DID_DEV_LO_BIT    21
`define DID_REG_HI        20
`define DID_REG_LO        18
`define DID_CH_HI         17
`define DID_CH_LO         16
`define DID_PAY_HI        15
`define DID_PAY_LO        0
`define DID_CMD_W         24
`define DID_FRAME_W       32
`define DID_CHECK_W       8
`define DID_RW_READ       1'b1

// Frame lengths in bits
`define DID_LEN_PLAIN     6'd24
`define DID_LEN_CHECKED   6'd32
`define DID_CNT_MAX       6'h3F

// Channel count and reset values
`define DID_NUM_CH        4
`define DID_DATA_RST      16'h0000
`define DID_GAIN_RST      16'hFFFF
`define DID_OFFS_RST      16'h0000
`define DID_CLEAR_RST     16'h0000
`define DID_CTRLW_RST     18'h00000

// APB register map, byte addresses
`define DID_ADDR_CTRL     8'h00
`define DID_ADDR_STATUS   8'h04
`define DID_ADDR_LAST     8'h08
`define DID_ADDR_CTRLW    8'h0C
`define DID_ADDR_COUNT    8'h50
`define DID_BANK_DATA     4'h1
`define DID_BANK_GAIN     4'h2
`define DID_BANK_OFFS     4'h3
`define DID_BANK_CLEAR    4'h4

// Control register fields
`define DID_CTRL_CHECK_EN 0
`define DID_CTRL_SOFT_RST 1

// Status register fields
`define DID_ST_FRAME_ERR  0
`define DID_ST_MISMATCH   1
`define DID_ST_BUSY       2
`define DID_ST_CAL_LO     4
`define DID_ST_CHECK_LO   8

`endif

// ==== pkg/did_pkg.sv ====
`default_nettype none

package did_pkg;

  typedef enum logic [2:0]
  {
    DID_REG_DATA     = 3'h0,
    DID_REG_NONE     = 3'h1,
    DID_REG_GAIN     = 3'h2,
    DID_REG_GAIN_ALL = 3'h3,
    DID_REG_OFFS     = 3'h4,
    DID_REG_OFFS_ALL = 3'h5,
    DID_REG_CLEAR    = 3'h6,
    DID_REG_CTRL     = 3'h7
  } did_regsel_t;

  typedef enum logic [1:0]
  {
    DID_RX_IDLE  = 2'h0,
    DID_RX_SHIFT = 2'h1,
    DID_RX_END   = 2'h3
  } did_rx_state_t;

endpackage

`default_nettype wire

// ==== rtl/did_sync.sv ====
`default_nettype none

module did_sync #(
  parameter int              WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_resetn,
  // Level crossing
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta   <= RESET_VAL;
      o_sync <= RESET_VAL;
    end
    else
    begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/did_shift.sv ====
`include "did_defines.svh"
`default_nettype none

module did_shift (
  // Clock and reset
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_resetn,
  // Synchronised link
  input  wire logic                      i_sclk,
  input  wire logic                      i_sync_n,
  input  wire logic                      i_sdin,
  input  wire logic                      i_check_en,
  // Received frame
  output logic                           o_word_valid,
  output logic                           o_len_err,
  output logic [`DID_CMD_W-1:0]          o_word,
  output logic [`DID_CHECK_W-1:0]        o_check,
  output logic                           o_busy
);

  did_pkg::did_rx_state_t     state;
  logic                       sclk_d;
  logic                       sync_d;
  logic [5:0]                 cnt;
  logic [`DID_FRAME_W-1:0]    shreg;
  logic                       sclk_fall;
  logic                       frame_start;
  logic                       frame_end;
  logic [5:0]                 want_len;

  // Data is taken on the falling link clock edge
  assign sclk_fall   = sclk_d & ~i_sclk;
  assign frame_start = sync_d & ~i_sync_n;
  assign frame_end   = ~sync_d & i_sync_n;
  assign want_len    = i_check_en ? `DID_LEN_CHECKED : `DID_LEN_PLAIN;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sclk_d <= 1'b0;
      sync_d <= 1'b1;
    end
    else
    begin
      sclk_d <= i_sclk;
      sync_d <= i_sync_n;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      state <= did_pkg::DID_RX_IDLE;
    else
    begin
      case (state)
        did_pkg::DID_RX_IDLE:
          if (frame_start)
            state <= did_pkg::DID_RX_SHIFT;
        did_pkg::DID_RX_SHIFT:
          if (frame_end)
            state <= did_pkg::DID_RX_END;
        did_pkg::DID_RX_END:
          state <= did_pkg::DID_RX_IDLE;
        default:
          state <= did_pkg::DID_RX_IDLE;
      endcase
    end
  end

  // Counter saturates so an overlong frame is still caught as bad
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt   <= 6'h00;
      shreg <= '0;
    end
    else if (state == did_pkg::DID_RX_IDLE && frame_start)
    begin
      cnt   <= 6'h00;
      shreg <= '0;
    end
    else if (state == did_pkg::DID_RX_SHIFT && sclk_fall)
    begin
      shreg <= {shreg[`DID_FRAME_W-2:0], i_sdin};
      if (cnt != `DID_CNT_MAX)
        cnt <= cnt + 6'h01;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_word_valid <= 1'b0;
      o_len_err    <= 1'b0;
      o_word       <= '0;
      o_check      <= '0;
      o_busy       <= 1'b0;
    end
    else
    begin
      o_busy       <= (state == did_pkg::DID_RX_SHIFT);
      o_word_valid <= (state == did_pkg::DID_RX_END) && (cnt == want_len); // RULE9 RULE10
      o_len_err    <= (state == did_pkg::DID_RX_END) && (cnt != want_len); // RULE9 RULE10
      if (state == did_pkg::DID_RX_END)
      begin
        if (i_check_en)
        begin
          o_word  <= shreg[`DID_FRAME_W-1:`DID_CHECK_W]; // RULE10
          o_check <= shreg[`DID_CHECK_W-1:0];
        end
        else
        begin
          o_word  <= shreg[`DID_CMD_W-1:0]; // RULE9
          o_check <= '0;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ==== rtl/did_top.sv ====
// Contract
// RULE1: After power-up the host resets the device before any configuration.
// RULE2: The host programs the boost supply settings before any channel.
// RULE3: The host then writes each channel control word with output off.
// RULE4: A channel data write starts a calibration of that channel.
// RULE5: The host waits at least 200 us after the data write before enabling.
// RULE6: The host finally rewrites channel control with output drive enabled.
// RULE7: A range change repeats the channel setup without supply settings.
// RULE8: The host should bring the output to zero scale before disabling it.
// RULE9: Without error checking a serial word is exactly 24 bits.
// RULE10: With error checking a word is 32 bits, the last 8 the check code.
// RULE11: The top bit of the command selects read or write.
// RULE12: The two device-select bits must both match the address pins.
// RULE13: Register select 000 is a channel data write, others differ.
// RULE14: A data write takes the low sixteen bits as the code.
// RULE15: Channel select 00..11 picks channels A..D, ignored when irrelevant.
// RULE16: Select 010/011 gain, 100/101 offset, 110 clear code, 111 control.
// RULE17: A word for another device address changes nothing. The code still sets the sticky mismatch status flag for it.
//
// Added by the designer: the APB register port and the placing of the registers.
`include "did_defines.svh"
`default_nettype none

module did_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // Serial link
  input  wire logic              i_sclk,
  input  wire logic              i_sync_n,
  input  wire logic              i_sdin,
  // Address pins
  input  wire logic              i_address_pin_hi,
  input  wire logic              i_address_pin_lo,
  // Converter side
  output logic [`DID_NUM_CH-1:0] o_cal_start,
  output logic                   o_read_req
);

  logic [4:0]               pins_sync;
  logic                     sclk_s;
  logic                     sync_n_s;
  logic                     sdin_s;
  logic                     addr_hi_s;
  logic                     addr_lo_s;
  logic                     word_valid;
  logic                     len_err;
  logic [`DID_CMD_W-1:0]    word;
  logic [`DID_CHECK_W-1:0]  check_byte;
  logic                     rx_busy;

  logic                     check_en;
  logic                     soft_rst;
  logic                     frame_err;
  logic                     mismatch;
  logic [`DID_NUM_CH-1:0]   cal_req;
  logic [`DID_CHECK_W-1:0]  last_check;
  logic [`DID_CMD_W-1:0]    last_word;
  logic [17:0]              ctrl_word;
  logic [15:0]              cnt_ok;
  logic [15:0]              cnt_bad;
  logic [15:0]              data_reg  [`DID_NUM_CH];
  logic [15:0]              gain_reg  [`DID_NUM_CH];
  logic [15:0]              offs_reg  [`DID_NUM_CH];
  logic [15:0]              clear_reg [`DID_NUM_CH];

  logic                     dev_match;
  logic                     accept_wr;
  logic                     accept_rd;
  did_pkg::did_regsel_t     sel;
  logic [1:0]               ch;
  logic [15:0]              payload;

  logic                     access;
  logic                     wr_fire;
  logic [31:0]              rd_val;
  logic                     rd_ok;
  logic [31:0]              status_val;
  logic [31:0]              st_clr;

  // Every pin crosses two flops before use
  // Reset levels match the idle link, so no false frame edge after reset
  did_sync #(
    .WIDTH     (5),
    .RESET_VAL (5'h0C)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_async   ({i_sdin, i_sync_n, i_sclk, i_address_pin_hi,
                 i_address_pin_lo}),
    .o_sync    (pins_sync)
  );

  assign sdin_s    = pins_sync[4];
  assign sync_n_s  = pins_sync[3];
  assign sclk_s    = pins_sync[2];
  assign addr_hi_s = pins_sync[1];
  assign addr_lo_s = pins_sync[0];

  did_shift u_shift (
    .i_clk_sys    (i_clk_sys),
    .i_resetn     (i_resetn),
    .i_sclk       (sclk_s),
    .i_sync_n     (sync_n_s),
    .i_sdin       (sdin_s),
    .i_check_en   (check_en),
    .o_word_valid (word_valid),
    .o_len_err    (len_err),
    .o_word       (word),
    .o_check      (check_byte),
    .o_busy       (rx_busy)
  );

  // True when a write with this select reaches channel idx
  function automatic logic chan_write(
    input did_pkg::did_regsel_t s,
    input did_pkg::did_regsel_t one,
    input logic                 has_all,
    input logic [1:0]           c,
    input logic [1:0]           idx
  );
    logic all_hit;
    all_hit    = has_all &&
                 (s == did_pkg::did_regsel_t'(one + 3'h1));
    chan_write = ((s == one) && (c == idx)) || all_hit; // RULE15
  endfunction

  assign dev_match = (word[`DID_DEV_HI_BIT] == addr_hi_s) &&
                     (word[`DID_DEV_LO_BIT] == addr_lo_s); // RULE12
  assign accept_wr = word_valid && dev_match &&
                     (word[`DID_RW_BIT] != `DID_RW_READ); // RULE11 RULE17
  assign accept_rd = word_valid && dev_match &&
                     (word[`DID_RW_BIT] == `DID_RW_READ); // RULE11 RULE17
  assign sel       = did_pkg::did_regsel_t'(word[`DID_REG_HI:`DID_REG_LO]); // RULE13
  assign ch        = word[`DID_CH_HI:`DID_CH_LO];
  assign payload   = word[`DID_PAY_HI:`DID_PAY_LO]; // RULE14

  // Channel registers; a mismatched word never gets here
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int i = 0; i < `DID_NUM_CH; i++)
      begin
        data_reg[i]  <= `DID_DATA_RST;
        gain_reg[i]  <= `DID_GAIN_RST;
        offs_reg[i]  <= `DID_OFFS_RST;
        clear_reg[i] <= `DID_CLEAR_RST;
      end
    end
    else if (soft_rst)
    begin
      for (int i = 0; i < `DID_NUM_CH; i++)
      begin
        data_reg[i]  <= `DID_DATA_RST;
        gain_reg[i]  <= `DID_GAIN_RST;
        offs_reg[i]  <= `DID_OFFS_RST;
        clear_reg[i] <= `DID_CLEAR_RST;
      end
    end
    else if (accept_wr)
    begin
      for (int i = 0; i < `DID_NUM_CH; i++)
      begin
        if (chan_write(sel, did_pkg::DID_REG_DATA, 1'b0, ch, 2'(i)))
          data_reg[i] <= payload; // RULE13 RULE14
        if (chan_write(sel, did_pkg::DID_REG_GAIN, 1'b1, ch, 2'(i)))
          gain_reg[i] <= payload; // RULE16
        if (chan_write(sel, did_pkg::DID_REG_OFFS, 1'b1, ch, 2'(i)))
          offs_reg[i] <= payload; // RULE16
        if (chan_write(sel, did_pkg::DID_REG_CLEAR, 1'b0, ch, 2'(i)))
          clear_reg[i] <= payload; // RULE16
      end
    end
  end

  // Control words need a further decode downstream, so keep them whole
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      ctrl_word <= `DID_CTRLW_RST;
    else if (soft_rst)
      ctrl_word <= `DID_CTRLW_RST;
    else if (accept_wr && sel == did_pkg::DID_REG_CTRL)
      ctrl_word <= {ch, payload}; // RULE16
  end

  // Calibration kick and read request toward the converter
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_cal_start <= '0;
      o_read_req  <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < `DID_NUM_CH; i++)
        o_cal_start[i] <= accept_wr &&
          chan_write(sel, did_pkg::DID_REG_DATA, 1'b0, ch, 2'(i)); // RULE4
      o_read_req <= accept_rd; // RULE11
    end
  end

  // Word history and counters
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      last_word  <= '0;
      last_check <= '0;
      cnt_ok     <= 16'h0000;
      cnt_bad    <= 16'h0000;
    end
    else
    begin
      if (word_valid && dev_match)
      begin
        last_word  <= word;
        last_check <= check_byte;
        cnt_ok     <= cnt_ok + 16'h0001;
      end
      if (len_err)
        cnt_bad <= cnt_bad + 16'h0001;
    end
  end

  // APB: one wait state, so prdata and pready both leave flip-flops
  assign access  = i_psel && i_penable;
  assign wr_fire = access && i_pwrite && o_pready;
  assign st_clr  = (wr_fire && i_paddr == `DID_ADDR_STATUS) ? i_pwdata
                                                            : 32'h0000_0000;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      check_en <= 1'b0;
      soft_rst <= 1'b0;
    end
    else
    begin
      soft_rst <= wr_fire && (i_paddr == `DID_ADDR_CTRL) &&
                  i_pwdata[`DID_CTRL_SOFT_RST]; // RULE1
      if (wr_fire && i_paddr == `DID_ADDR_CTRL)
        check_en <= i_pwdata[`DID_CTRL_CHECK_EN]; // RULE10
    end
  end

  // Sticky flags: a new event beats a clear in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      frame_err <= 1'b0;
      mismatch  <= 1'b0;
      cal_req   <= '0;
    end
    else
    begin
      frame_err <= (frame_err & ~st_clr[`DID_ST_FRAME_ERR]) | len_err;
      mismatch  <= (mismatch & ~st_clr[`DID_ST_MISMATCH]) |
                   (word_valid & ~dev_match); // RULE17
      cal_req   <= (cal_req &
                    ~st_clr[`DID_ST_CAL_LO +: `DID_NUM_CH]) | o_cal_start;
    end
  end

  always_comb
  begin
    status_val = 32'h0000_0000;
    status_val[`DID_ST_FRAME_ERR] = frame_err;
    status_val[`DID_ST_MISMATCH]  = mismatch;
    status_val[`DID_ST_BUSY]      = rx_busy;
    status_val[`DID_ST_CAL_LO +: `DID_NUM_CH]  = cal_req;
    status_val[`DID_ST_CHECK_LO +: `DID_CHECK_W] = last_check;
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_ok  = (i_paddr[1:0] == 2'h0);
    case (i_paddr[7:4])
      4'h0:
        case (i_paddr)
          `DID_ADDR_CTRL:   rd_val = {31'h0, check_en};
          `DID_ADDR_STATUS: rd_val = status_val;
          `DID_ADDR_LAST:   rd_val = {8'h00, last_word};
          `DID_ADDR_CTRLW:  rd_val = {14'h0000, ctrl_word};
          default:          rd_ok  = 1'b0;
        endcase
      `DID_BANK_DATA:  rd_val = {16'h0000, data_reg[i_paddr[3:2]]};
      `DID_BANK_GAIN:  rd_val = {16'h0000, gain_reg[i_paddr[3:2]]};
      `DID_BANK_OFFS:  rd_val = {16'h0000, offs_reg[i_paddr[3:2]]};
      `DID_BANK_CLEAR: rd_val = {16'h0000, clear_reg[i_paddr[3:2]]};
      default:
      begin
        if (i_paddr == `DID_ADDR_COUNT)
          rd_val = {cnt_bad, cnt_ok};
        else
          rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready <= access && !o_pready;
      if (access && !o_pready)
      begin
        o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_val;
        o_pslverr <= !rd_ok;
      end
      else
      begin
        o_prdata  <= 32'h0000_0000;
        o_pslverr <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ==== test/did_checker_asserts.sv ====
`default_nettype none

module did_checker #(
  parameter int ADDR_W = 8
) (
  // Clock, reset and bus
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic              o_pready,
  // Serial link and pins
  input  wire logic              i_sclk,
  input  wire logic              i_sync_n,
  input  wire logic              i_sdin,
  input  wire logic              i_address_pin_hi,
  input  wire logic              i_address_pin_lo,
  // Converter side
  input  wire logic [3:0]        o_cal_start,
  input  wire logic              o_read_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        sclk_q;
  logic        sync_q;
  logic        mode;
  logic [31:0] sh;
  logic [5:0]  cnt;
  logic [4:0]  since;
  logic [23:0] w;
  logic        fr_end;
  logic        ok;
  // Own copy of the word, taken at the pins; the link idles between frames
  assign fr_end = !sync_q && i_sync_n;
  assign w = mode ? sh[31:8] : sh[23:0];
  assign ok = fr_end && cnt == (mode ? 6'd32 : 6'd24)
    && w[22] == i_address_pin_hi && w[21] == i_address_pin_lo;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
    if (!i_resetn)
    begin
      sclk_q <= 1'b1;
      sync_q <= 1'b1;
      mode <= 1'b0;
      sh <= 32'h0;
      cnt <= 6'h0;
      since <= 5'h1F;
    end
    else
    begin
      sclk_q <= i_sclk;
      sync_q <= i_sync_n;
      if (sync_q && !i_sync_n)
        cnt <= 6'h0;
      else if (!i_sync_n && sclk_q && !i_sclk)
      begin
        sh <= {sh[30:0], i_sdin};
        cnt <= cnt + 6'h1;
      end
      if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == '0)
        mode <= i_pwdata[0];
      since <= fr_end ? 5'h0 : (since == 5'h1F ? since : since + 5'h1);
    end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  property p_cal_data;
    ok && !w[23] && w[20:18] == 3'h0
      |-> ##[2:10] o_cal_start == (4'h1 << w[17:16]);
  endproperty
  a_cal_data: assert property (p_cal_data)
    else $error("no calibration pulse for data write");
  property p_foreign;
    fr_end && w[22:21] != {i_address_pin_hi, i_address_pin_lo}
      |=> (o_cal_start == 4'h0 && !o_read_req) [*8];
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("foreign word acted on");
  property p_len24;
    fr_end && !mode && cnt != 6'd24 |=> (o_cal_start == 4'h0) [*8];
  endproperty
  a_len24: assert property (p_len24)
    else $error("bad length plain frame acted on");
  property p_len32;
    fr_end && mode && cnt != 6'd32 |=> (o_cal_start == 4'h0) [*8];
  endproperty
  a_len32: assert property (p_len32)
    else $error("bad length checked frame acted on");
  property p_read;
    ok && w[23] |-> ##[2:10] o_read_req;
  endproperty
  a_read: assert property (p_read)
    else $error("read word gave no read request");
  property p_read_quiet;
    ok && w[23] |=> (o_cal_start == 4'h0) [*8];
  endproperty
  a_read_quiet: assert property (p_read_quiet)
    else $error("read word started calibration");
  property p_other;
    ok && !w[23] && w[20:18] != 3'h0
      |=> (o_cal_start == 4'h0 && !o_read_req) [*8];
  endproperty
  a_other: assert property (p_other)
    else $error("non data write started calibration");
  property p_cause;
    o_cal_start != 4'h0
      |-> $onehot(o_cal_start) && since >= 5'd1 && since <= 5'd10;
  endproperty
  a_cause: assert property (p_cause)
    else $error("calibration pulse without frame or not one channel");
endmodule

bind did_top did_checker #(.ADDR_W(ADDR_W)) u_did_checker (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_pready(o_pready), .i_sclk(i_sclk),
  .i_sync_n(i_sync_n), .i_sdin(i_sdin),
  .i_address_pin_hi(i_address_pin_hi), .i_address_pin_lo(i_address_pin_lo),
  .o_cal_start(o_cal_start), .o_read_req(o_read_req)
);

`default_nettype wire

// ==== test/did_host.sv ====
`default_nettype none

module did_host (
  // Link pins
  output var logic o_sclk,
  output var logic o_sync_n,
  output var logic o_sdin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_sclk = 1'b1;
    o_sync_n = 1'b1;
    o_sdin = 1'b0;
  end
  // Frame of n bits, MSB first; clock stands still between frames
  task automatic send(input logic [31:0] bits, input int n);
    #13 o_sync_n = 1'b0;
    #160;
    for (int i = n - 1; i >= 0; i--)
    begin
      o_sdin = bits[i];
      #160 o_sclk = 1'b0;
      #160 o_sclk = 1'b1;
    end
    #160 o_sync_n = 1'b1;
    o_sdin = ~o_sdin;
    #800;
  endtask
endmodule

`default_nettype wire

// ==== test/did_top_test.sv ====
`default_nettype none

module did_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, psel, pen, pwr, pready, pslverr, err;
  logic        sclk, sync_n, sdin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] m [16];
  logic [3:0]  cal;
  logic        rreq;
  int          cal_cnt = 0;
  int          rreq_cnt = 0;
  int          fail_count = 0;
  int          samples_checked = 0;

  did_top #(.ADDR_W(8)) u_did_top (
    .i_clk_sys(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_sclk(sclk),
    .i_sync_n(sync_n), .i_sdin(sdin), .i_address_pin_hi(1'b1),
    .i_address_pin_lo(1'b0), .o_cal_start(cal), .o_read_req(rreq)
  );
  did_host u_did_host (.o_sclk(sclk), .o_sync_n(sync_n), .o_sdin(sdin));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Pulses last one cycle, so each rising edge counts one at most once
  always @(posedge clk)
  begin
    cal_cnt <= cal_cnt + $countones(cal);
    rreq_cnt <= rreq_cnt + int'(rreq);
  end

  task automatic close_out();
    $display("Checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error reg %0h expected %0h seen %0h", a, e, g);
    end
  endtask

  task automatic chk_cnt(input string nm, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // Held until ready is seen; one idle cycle after, so no double drive
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    // Link frames end off the clock edge, so realign first
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    if (n >= 50)
      fail_count++;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] msk, e);
    apb(1'b0, a, 32'h0);
    chk(a, e, rd & msk);
  endtask

  task automatic chk_all();
    for (int i = 0; i < 16; i++)
      rchk(8'h10 + 8'(4 * i), 32'h0000FFFF, {16'h0, m[i]});
  endtask

  function automatic logic [23:0] mk(logic r, logic [1:0] dv, logic [2:0] s,
                                     logic [1:0] c, logic [15:0] p);
    return {r, dv, s, c, p};
  endfunction

  // Addressed write; the model mirrors which registers it must touch
  task automatic put(input logic [2:0] s, input logic [1:0] c,
                     input logic [15:0] p);
    u_did_host.send({8'h00, mk(1'b0, 2'h2, s, c, p)}, 24);
    if (s != 3'h1 && s != 3'h7)
      for (int i = 0; i < 4; i++)
        if (i == c || s == 3'h3 || s == 3'h5)
          m[(s >> 1) * 4 + i] = p;
  endtask

  initial
  begin
    rstn = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    for (int i = 0; i < 16; i++)
      m[i] = (i >= 4 && i < 8) ? 16'hFFFF : 16'h0000;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk_all();
    apb(1'b0, 8'h60, 32'h0);
    chk(8'h60, 32'h1, {31'h0, err});
    apb(1'b1, 8'h00, 32'h2);
    put(3'h7, 2'h0, 16'h1234);
    rchk(8'h0C, 32'h3FFFF, 32'h01234);
    for (int c = 0; c < 4; c++)
    begin
      put(3'h7, c[1:0], 16'h0100);
      put(3'h0, c[1:0], 16'h8000 + 16'(c));
      rchk(8'h04, 32'h10 << c, 32'h10 << c);
      repeat (5000) @(posedge clk);
      put(3'h7, c[1:0], 16'h0140);
    end
    put(3'h0, 2'h0, 16'h0000);
    put(3'h7, 2'h0, 16'h0200);
    chk_all();
    for (int s = 1; s < 7; s++)
      put(s[2:0], 2'h1, 16'hA000 + 16'(s));
    chk_all();
    for (int d = 0; d < 4; d++)
      if (d != 2)
        u_did_host.send({8'h0, mk(1'b0, d[1:0], 3'h0, 2'h0, 16'h7777)}, 24);
    chk_all();
    rchk(8'h04, 32'h2, 32'h2);
    u_did_host.send({8'h0, mk(1'b1, 2'h2, 3'h0, 2'h3, 16'h3333)}, 24);
    chk_all();
    rchk(8'h08, 32'hFFFFFF, {8'h0, mk(1'b1, 2'h2, 3'h0, 2'h3, 16'h3333)});
    u_did_host.send(32'h0, 23);
    u_did_host.send(32'h0, 25);
    rchk(8'h50, 32'hFFFF0000, 32'h00020000);
    apb(1'b1, 8'h00, 32'h1);
    u_did_host.send({mk(1'b0, 2'h2, 3'h0, 2'h2, 16'hBEEF), 8'h5A}, 32);
    m[2] = 16'hBEEF;
    rchk(8'h04, 32'hFF00, 32'h5A00);
    u_did_host.send({8'h0, mk(1'b0, 2'h2, 3'h0, 2'h2, 16'h1111)}, 24);
    rchk(8'h50, 32'hFFFF0000, 32'h00030000);
    chk_all();
    chk_cnt("cal pulses", 8'd6, 8'(cal_cnt));
    chk_cnt("read pulses", 8'd1, 8'(rreq_cnt));
    close_out();
  end

  initial
  begin
    #3000000;
    fail_count++;
    close_out();
  end
endmodule

`default_nettype wire
